// [inc/icpd_pkg.sv]
// ****************************************
// shared constants of the page decoder
// ****************************************
package icpd_pkg;

	// base map width before the core-number field is added
	localparam int BASE_AW    = 18;
	// lowest bit of the 64KB page index
	localparam int PAGE_LSB   = 16;
	// lowest bit of the core-number field
	localparam int CORE_LSB   = 17;
	localparam int PAGE_OFF_W = 16;
	localparam int NUM_GLOBAL = 4;

	// global page indices
	localparam logic [1:0] PG_DIST     = 2'h0;
	localparam logic [1:0] PG_MSG_SPI  = 2'h1;
	localparam logic [1:0] PG_XLAT_CTL = 2'h2;
	localparam logic [1:0] PG_DOORBELL = 2'h3;

	// bus answer, burst and size codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [2:0] SIZE_WORD   = 3'h2;

	// values after reset
	localparam logic [31:0] RDATA_RST  = 32'h0000_0000;
	localparam logic [7:0]  LEN_RST    = 8'h00;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_WRITE = 5'b00010,
		ST_WRESP = 5'b00100,
		ST_READ  = 5'b01000,
		ST_RDATA = 5'b10000
	} icpd_state_t;

endpackage

// [test/icpd_page_decoder_asserts.sv]
`timescale 1ns/10ps
// ****
// checker
// ****
module icpd_asserts #(
	parameter int NC = 16
) (
	input wire logic          clock,
	input wire logic          rst,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic          awvalid,
	input wire logic          rvalid,
	input wire logic          rready,
	input wire logic [31:0]   rdata,
	input wire logic [1:0]    rresp,
	input wire logic          bvalid,
	input wire logic          bready,
	input wire logic [1:0]    bresp,
	input wire logic          regReq,
	input wire logic          regWrite,
	input wire logic [31:0]   regRdata,
	input wire logic [3:0]    globalSel,
	input wire logic [NC-1:0] coreCtlSel,
	input wire logic [NC-1:0] coreSgiSel,
	input wire logic          reservedHit
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence rd_taken; arvalid && arready; endsequence
	sequence rsvd_read; reservedHit && !regWrite; endsequence
	a_one_select: assert property (regReq |->
		$onehot({globalSel, coreCtlSel, coreSgiSel})) else $error("bad select");
	a_rsvd_quiet: assert property (reservedHit |-> !regReq && !globalSel)
		else $error("reserved beat reached a page");
	a_read_lat: assert property (rd_taken |-> ##2 rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata)) else $error("read answer dropped");
	a_b_hold: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp)) else $error("write answer dropped");
	a_rsvd_zero: assert property (rsvd_read |=>
		rvalid && rdata == 32'h0 && rresp == 2'h0) else $error("reserved data");
	a_rd_data: assert property (regReq && !regWrite |=>
		rdata == $past(regRdata)) else $error("read data altered");
	a_rst_clear: assert property (disable iff (1'b0) rst |=>
		!rvalid && !bvalid && !regReq) else $error("reset left activity");
	a_ar_yield: assert property (arready |-> !awvalid)
		else $error("read taken over write");
endmodule

bind icpd_page_decoder icpd_asserts #(.NC(NUM_CLUSTERS*CORES_PER_CLUSTER))
	icpd_asserts_inst (.clock, .rst, .arvalid, .arready, .awvalid, .rvalid,
	.rready, .rdata, .rresp, .bvalid, .bready, .bresp, .regReq, .regWrite,
	.regRdata, .globalSel, .coreCtlSel, .coreSgiSel, .reservedHit);

// [test/icpd_page_model.sv]
`timescale 1ns/10ps
// ****
// page responder
// ****
module icpd_page_model (
	input  wire logic [15:0] regAddr,
	output logic      [31:0] regRdata,
	output logic             regSubWordOk
);
	// offset in upper half shows byte order
	assign regRdata = {regAddr, ~regAddr};
	// narrow sizes only where bit 2 set
	assign regSubWordOk = regAddr[2];
endmodule

// [test/tb_icpd_page_decoder.sv]
`timescale 1ns/10ps
// ****
// bench
// ****
module tb_icpd_page_decoder;
	// twelve cores so that core numbers 12..15 are absent
	localparam int NC = 12;
	logic clock, rst, awvalid, wlast, wvalid, bready, arvalid, rready;
	logic regSubWordOk, awready, wready, bvalid, arready, rvalid, rlast;
	logic regReq, regWrite, reservedHit;
	logic [3:0] awid, arid, wstrb, bid, rid, globalSel, regStrb;
	logic [21:0] awaddr, araddr;
	logic [7:0] awlen, arlen;
	logic [2:0] awsize, arsize;
	logic [1:0] awburst, arburst, bresp, rresp;
	logic [31:0] wdata, regRdata, rdata, regWdata, r, rr;
	logic [15:0] regAddr;
	logic [NC-1:0] coreCtlSel, coreSgiSel;
	logic [38:0] respQ[$];
	logic [80:0] selQ[$];
	logic [21:0] da[8] = '{22'h000000, 22'h010004, 22'h020004, 22'h030004,
		22'h040004, 22'h200004, 22'h370004, 22'h390004};
	int errTotal, totalChecks, seed;

	icpd_page_decoder #(.NUM_CLUSTERS(3), .CORES_PER_CLUSTER(4))
		icpd_page_decoder_inst (.clock, .rst, .awid, .awaddr, .awlen, .awsize,
		.awburst, .awvalid, .awready, .wdata, .wstrb, .wlast, .wvalid, .wready,
		.bid, .bresp, .bvalid, .bready, .arid, .araddr, .arlen, .arsize,
		.arburst, .arvalid, .arready, .rid, .rdata, .rresp, .rlast, .rvalid,
		.rready, .regReq, .regWrite, .regAddr, .regWdata, .regStrb,
		.globalSel, .coreCtlSel, .coreSgiSel, .reservedHit, .regRdata,
		.regSubWordOk);
	icpd_page_model icpd_page_model_inst (.regAddr, .regRdata, .regSubWordOk);

	task reportAndStop;
		$display("checks %0d mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [80:0] e, logic [80:0] s);
		totalChecks++;
		if (e !== s) begin
			errTotal++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	function logic hs(int k);
		return k == 0 ? awready : k == 1 ? wready : k == 2 ? arready :
			k == 3 ? bvalid && bready : rvalid && rready;
	endfunction

	task automatic waitfor(int k);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (!hs(k) && n < 60);
		if (!hs(k)) begin
			errTotal++;
			reportAndStop;
		end
	endtask

	task automatic xfer(bit wr, logic [21:0] a, logic [2:0] sz);
		logic [31:0] q;
		logic [28:0] e;
		logic rs, bad;
		q = $random(seed);
		rs = a[21] ? a[20:17] >= NC : a[20:16] > 5'h3;
		bad = sz < 3'h2 && !rs && !a[2];
		e = '0;
		if (rs)
			e[28] = 1'b1;
		else if (a[21])
			e[4 + NC * a[16] + a[20:17]] = 1'b1;
		else
			e[a[17:16]] = 1'b1;
		if (!bad)
			selQ.push_back({wr ? q[7:4] : 4'h0, wr ? q : 32'h0, a[15:0], e});
		respQ.push_back({!wr, q[3:0], bad ? 2'h2 : 2'h0,
			wr || rs || bad ? 32'h0 : {a[15:0], ~a[15:0]}});
		@(posedge clock);
		#1;
		if (wr) begin
			{awid, awaddr, awsize, wdata, wstrb} = {q[3:0], a, sz, q, q[7:4]};
			awvalid = 1;
			wvalid = 1;
			waitfor(0);
			#1;
			awvalid = 0;
			waitfor(1);
			#1;
			wvalid = 0;
			waitfor(3);
		end else begin
			{arid, araddr, arsize} = {q[3:0], a, sz};
			arvalid = 1;
			waitfor(2);
			#1;
			arvalid = 0;
			waitfor(4);
		end
	endtask

	// answers are stalled at random to exercise holding
	always @(posedge clock) begin
		#1;
		rr = $random(seed);
		{rready, bready} = rr[1:0];
	end

	always @(posedge clock) begin
		if (!rst && (regReq || reservedHit))
			chk("select", selQ.size() ? selQ.pop_front() : 'x,
				{regStrb, regWrite ? regWdata : 32'h0, regAddr,
				reservedHit, coreSgiSel, coreCtlSel, globalSel});
		if (!rst && bvalid && bready)
			chk("write answer", respQ.pop_front(), {1'b0, bid, bresp, 32'h0});
		// every bit of read data is compared, reserved pages against zero
		if (!rst && rvalid && rready)
			chk("read answer", respQ.pop_front(), {rlast, rid, rresp, rdata});
	end

	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end

	initial begin
		seed = 38;
		rst = 1;
		{awvalid, wvalid, arvalid, rready, bready} = '0;
		{awid, arid, awaddr, araddr, awsize, arsize, wdata, wstrb} = '0;
		{awlen, arlen} = '0;
		{awburst, arburst} = 4'h5;
		wlast = 1;
		repeat (20) @(posedge clock);
		#1;
		rst = 0;
		foreach (da[i])
			for (int k = 0; k < 4; k++)
				xfer(k[0], da[i], k[1] ? 3'h2 : 3'h0);
		$display("directed pages done");
		@(posedge clock);
		#1;
		rst = 1;
		repeat (2) @(posedge clock);
		#1;
		rst = 0;
		chk("idle after reset", {awready, bvalid, rvalid, regReq}, 4'h8);
		$display("mid-run reset done");
		repeat (60) begin
			r = $random(seed);
			xfer(r[31], {r[21:2], 2'h0}, r[1:0] == 2'h3 ? 3'h2 : {1'b0, r[1:0]});
		end
		$display("random traffic done");
		repeat (5) @(posedge clock);
		chk("queues drained", selQ.size() + respQ.size(), 0);
		reportAndStop;
	end
endmodule

// [verilog/icpd_page_decoder.sv]
`timescale 1ns/10ps

module icpd_page_decoder #(
	parameter int NUM_CLUSTERS      = 4,
	parameter int CORES_PER_CLUSTER = 4,
	parameter int AXI_AW            = 22,
	parameter int IDW               = 4
) (
	input  wire logic                 clock,
	input  wire logic                 rst,

	input  wire logic [IDW-1:0]       awid,
	input  wire logic [AXI_AW-1:0]    awaddr,
	input  wire logic [7:0]           awlen,
	input  wire logic [2:0]           awsize,
	input  wire logic [1:0]           awburst,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wlast,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [IDW-1:0]            bid,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,

	input  wire logic [IDW-1:0]       arid,
	input  wire logic [AXI_AW-1:0]    araddr,
	input  wire logic [7:0]           arlen,
	input  wire logic [2:0]           arsize,
	input  wire logic [1:0]           arburst,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [IDW-1:0]            rid,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rlast,
	output logic                      rvalid,
	input  wire logic                 rready,

	output logic                      regReq,
	output logic                      regWrite,
	output logic [15:0]               regAddr,
	output logic [31:0]               regWdata,
	output logic [3:0]                regStrb,
	output logic [3:0]                globalSel,
	output logic [NUM_CLUSTERS*CORES_PER_CLUSTER-1:0] coreCtlSel,
	output logic [NUM_CLUSTERS*CORES_PER_CLUSTER-1:0] coreSgiSel,
	output logic                      reservedHit,
	input  wire logic [31:0]          regRdata,
	input  wire logic                 regSubWordOk
);

	// ****************************************
	// map geometry
	// ****************************************
	localparam int NC  = NUM_CLUSTERS * CORES_PER_CLUSTER;
	localparam int CW  = (NC > 1) ? $clog2(NC) : 1;
	localparam int AW  = icpd_pkg::BASE_AW + CW;
	localparam int MSB = AW - 1;

	// ****************************************
	// transaction state
	// ****************************************
	icpd_pkg::icpd_state_t stateQ;
	icpd_pkg::icpd_state_t stateD;

	logic [AXI_AW-1:0] addr_q;
	logic [AXI_AW-1:0] addr_d;
	logic [7:0]        len_q;
	logic [7:0]        len_d;
	logic [2:0]        size_q;
	logic [2:0]        size_d;
	logic [1:0]        burst_q;
	logic [1:0]        burst_d;
	logic [IDW-1:0]    id_q;
	logic [IDW-1:0]    id_d;
	logic              err_q;
	logic              err_d;
	logic [31:0]       rdata_q;
	logic [31:0]       rdata_d;
	logic [1:0]        rresp_q;
	logic [1:0]        rresp_d;

	// ****************************************
	// address decode
	// ****************************************
	wire           inIdle   = (stateQ == icpd_pkg::ST_IDLE);
	wire           inWrite  = (stateQ == icpd_pkg::ST_WRITE);
	wire           inWresp  = (stateQ == icpd_pkg::ST_WRESP);
	wire           inRead   = (stateQ == icpd_pkg::ST_READ);
	wire           inRdata  = (stateQ == icpd_pkg::ST_RDATA);

	// bits above the map carry side data, never decoded
	wire           upperSet = addr_q[MSB];
	wire [CW:0]    pageIdx  = addr_q[MSB-1:icpd_pkg::PAGE_LSB];
	wire [CW-1:0]  coreNum  = addr_q[MSB-1:icpd_pkg::CORE_LSB];
	wire           sgiPage  = addr_q[icpd_pkg::PAGE_LSB];

	wire           lowHit   = !upperSet && ((pageIdx >> 2) == '0);
	wire           coreOk   = (32'(coreNum) < 32'(NC));
	wire           highHit  = upperSet && coreOk;
	wire           rsvd     = !(lowHit || highHit);

	wire           subErr   = (size_q < icpd_pkg::SIZE_WORD)
	                          && !regSubWordOk && !rsvd;
	wire           wrBeat   = inWrite && wvalid;
	wire           access   = wrBeat || inRead;
	wire           liveAcc  = access && !rsvd && !subErr;

	// each beat is its own atomic word
	wire [AXI_AW-1:0] step  = AXI_AW'(1) << size_q;
	wire           fixedB   = (burst_q == icpd_pkg::BURST_FIXED);
	wire [AXI_AW-1:0] nextA = fixedB ? addr_q : addr_q + step;

	// ****************************************
	// channel acceptance
	// ****************************************
	// each accept mirrors its ready output, so the state machine
	// and the handshake pins cannot drift apart

	// address channels, writes first
	wire           awTake   = inIdle && awvalid;
	wire           arTake   = inIdle && arvalid && !awvalid;

	// write beats and the closing answer
	wire           wTake    = wrBeat;
	wire           wEnd     = wTake && wlast;
	wire           bTake    = inWresp && bready;

	// read beats
	wire           lastBeat = (len_q == 8'h00);
	wire           rTake    = inRdata && rready;

	// a refusal on any beat marks the whole burst
	wire           wErrNext = err_q || subErr;
	// reserved and refused reads both answer zero
	wire           rZero    = rsvd || subErr;

	// ****************************************
	// page selects
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < icpd_pkg::NUM_GLOBAL; g = g + 1) begin : gGlob
			assign globalSel[g] = liveAcc && lowHit
			                      && (pageIdx == (CW+1)'(g));
		end
		// linear number runs cluster by cluster
		for (g = 0; g < NC; g = g + 1) begin : gCore
			assign coreCtlSel[g] = liveAcc && highHit
			                       && (coreNum == CW'(g)) && !sgiPage;
			assign coreSgiSel[g] = liveAcc && highHit
			                       && (coreNum == CW'(g)) && sgiPage;
		end
	endgenerate

	// ****************************************
	// downstream register port
	// ****************************************
	// no request reaches a reserved page
	assign regReq      = liveAcc;
	assign regWrite    = inWrite;
	assign regAddr     = addr_q[icpd_pkg::PAGE_OFF_W-1:0];
	assign regWdata    = wdata;
	assign regStrb     = inWrite ? wstrb : 4'h0;
	assign reservedHit = access && rsvd;

	// ****************************************
	// bus handshakes
	// ****************************************
	assign awready = inIdle;
	// writes win when both address channels arrive together
	assign arready = inIdle && !awvalid;
	assign wready  = inWrite;
	assign bvalid  = inWresp;
	assign bid     = id_q;
	assign bresp   = err_q ? icpd_pkg::RESP_SLVERR : icpd_pkg::RESP_OKAY;
	assign rvalid  = inRdata;
	assign rid     = id_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	assign rlast   = inRdata && lastBeat;

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		stateD  = stateQ;
		addr_d  = addr_q;
		len_d   = len_q;
		size_d  = size_q;
		burst_d = burst_q;
		id_d    = id_q;
		err_d   = err_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (stateQ)
			icpd_pkg::ST_IDLE: begin
				if (awTake) begin
					addr_d  = awaddr;
					len_d   = awlen;
					size_d  = awsize;
					burst_d = awburst;
					id_d    = awid;
					err_d   = 1'b0;
					stateD  = icpd_pkg::ST_WRITE;
				end else if (arTake) begin
					addr_d  = araddr;
					len_d   = arlen;
					size_d  = arsize;
					burst_d = arburst;
					id_d    = arid;
					stateD  = icpd_pkg::ST_READ;
				end
			end
			icpd_pkg::ST_WRITE: begin
				if (wTake) begin
					// refused beat is sticky for the burst
					err_d  = wErrNext;
					addr_d = nextA;
					if (wEnd) begin
						stateD = icpd_pkg::ST_WRESP;
					end
				end
			end
			icpd_pkg::ST_WRESP: begin
				if (bTake) begin
					stateD = icpd_pkg::ST_IDLE;
				end
			end
			icpd_pkg::ST_READ: begin
				if (rZero) begin
					rdata_d = icpd_pkg::RDATA_RST;
				end else begin
					rdata_d = regRdata;
				end
				rresp_d = subErr ? icpd_pkg::RESP_SLVERR
				                 : icpd_pkg::RESP_OKAY;
				stateD  = icpd_pkg::ST_RDATA;
			end
			icpd_pkg::ST_RDATA: begin
				if (rTake) begin
					if (lastBeat) begin
						stateD = icpd_pkg::ST_IDLE;
					end else begin
						len_d  = len_q - 8'h01;
						addr_d = nextA;
						stateD = icpd_pkg::ST_READ;
					end
				end
			end
			default: begin
				stateD = icpd_pkg::ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// state registers
	// ****************************************
	// everything but the state clears to zero; the state loads ST_IDLE
	always_ff @(posedge clock) begin
		if (rst) begin
			stateQ  <= icpd_pkg::ST_IDLE;
			addr_q  <= '0;
			len_q   <= icpd_pkg::LEN_RST;
			size_q  <= 3'h0;
			burst_q <= 2'h0;
			id_q    <= '0;
			err_q   <= 1'b0;
			rdata_q <= icpd_pkg::RDATA_RST;
			rresp_q <= icpd_pkg::RESP_OKAY;
		end else begin
			stateQ  <= stateD;
			addr_q  <= addr_d;
			len_q   <= len_d;
			size_q  <= size_d;
			burst_q <= burst_d;
			id_q    <= id_d;
			err_q   <= err_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

endmodule
